// File: include/sdma_regs.svh
/*
  Register offsets, field positions, reset values and event codes of the
  six-channel transfer engine. Assumes an 8-bit word address on the register
  port: bits 7:3 pick a page (channel 0-5, globals, control), bits 2:0 a word.
*/
`ifndef SDMA_REGS_SVH
`define SDMA_REGS_SVH

`define SDMA_NCH 6
`define SDMA_GLB_PAGE 5'h06
`define SDMA_CTL_PAGE 5'h07

`define SDMA_CH_SRC 3'h0
`define SDMA_CH_DST 3'h1
`define SDMA_CH_CNT 3'h2
`define SDMA_CH_SFC 3'h3
`define SDMA_CH_MOD 3'h4

`define SDMA_G_SRC 3'h0
`define SDMA_G_DST 3'h1
`define SDMA_G_CNT 3'h2
`define SDMA_G_FRM 3'h3
`define SDMA_G_EIA 3'h4
`define SDMA_G_EIB 3'h5
`define SDMA_G_FIA 3'h6
`define SDMA_G_FIB 3'h7

`define SDMA_C_PREC 3'h0
`define SDMA_C_STAT 3'h1

`define SDMA_SYN_HI 15
`define SDMA_SYN_LO 12
`define SDMA_FRM_HI 7
`define SDMA_FRM_LO 0
`define SDMA_EN_HI 5
`define SDMA_EN_LO 0
`define SDMA_PRI_HI 13
`define SDMA_PRI_LO 8
`define SDMA_RT_HI 15
`define SDMA_RT_LO 14
`define SDMA_MOD_SPARE 5'h00

`define SDMA_RST_WORD 16'h0000
`define SDMA_RST_FRM 8'h00
`define SDMA_RST_SYN 4'h0
`define SDMA_RST_RT 2'b00
`define SDMA_RST_CH 6'h00

`define SDMA_SYN_NONE 4'h0
`define SDMA_SYN_S0RX 4'h1
`define SDMA_SYN_S0TX 4'h2
`define SDMA_SYN_S1RX 4'h5
`define SDMA_SYN_S1TX 4'h6
`define SDMA_SYN_TMR0 4'hD
`define SDMA_SYN_EXT3 4'hE
`define SDMA_SYN_TMR1 4'hF

`define SDMA_RT_NONE 2'b00
`define SDMA_RT_CH23 2'b01
`define SDMA_RT_ALL 2'b10

`endif

// File: include/sdma_pkg.sv
/*
  Types shared by the transfer engine and its helpers.
  Assumes the constants of sdma_regs.svh for all numeric values.
*/
package sdma_pkg;
  typedef enum logic [1:0] {AM_CONST = 2'b00, AM_INC = 2'b01, AM_DEC = 2'b10, AM_INDEX = 2'b11} sdma_amode_e;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_RD = 2'b01, ST_LAT = 2'b10, ST_WR = 2'b11} sdma_state_e;
  typedef struct packed {
    logic auto_reload_enable;
    logic interrupt_mode_bit;
    logic channel_interrupt_enable;
    logic auto_buffer_mode;
    logic dword_mode;
    sdma_amode_e src_mode;
    logic source_index_select;
    sdma_amode_e dst_mode;
    logic destination_index_select;
    logic [4:0] spare;
  } sdma_mode_s;
  typedef struct packed {
    logic [15:0] element_index_a;
    logic [15:0] element_index_b;
    logic [15:0] frame_index_a;
    logic [15:0] frame_index_b;
  } sdma_index_s;
  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } sdma_mem_s;
  typedef struct packed {
    logic ser0_rx;
    logic ser0_tx;
    logic ser1_rx;
    logic ser1_tx;
    logic timer0;
    logic timer1;
  } sdma_evt_s;
endpackage

// File: design/sdma_addr_step.sv
/*
  Post-transfer address adjustment for one address of the active channel.
  Assumes mode, index select and last-in-frame come from the same cycle.
*/
`timescale 1ns/1ps
module sdma_addr_step
  import sdma_pkg::*;
(
  input wire logic [15:0] addr_in,
  input wire sdma_amode_e mode_in,
  input wire logic sel_in,
  input wire logic last_in,
  input wire sdma_index_s idx_in,
  output logic [15:0] addr_out
);
  wire [15:0] elem_amt = sel_in ? idx_in.element_index_b : idx_in.element_index_a;
  wire [15:0] frame_amt = sel_in ? idx_in.frame_index_b : idx_in.frame_index_a;
  wire [15:0] step_amt = last_in ? frame_amt : elem_amt;

  assign addr_out = (mode_in == AM_INC) ? addr_in + 16'h0001 :
                    (mode_in == AM_DEC) ? addr_in - 16'h0001 :
                    (mode_in == AM_INDEX) ? addr_in + step_amt : addr_in;
endmodule

// File: design/sdma_rr_arb.sv
/*
  Rotating arbiter over the six channels of one priority level.
  Assumes requests are held while the level waits; adv_in marks a grant taken.
*/
`timescale 1ns/1ps
module sdma_rr_arb
  import sdma_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic [5:0] req_in,
  input wire logic adv_in,
  output logic [5:0] gnt_out
);
  logic [2:0] last_q;
  logic [2:0] pick;

  always_comb begin
    logic hit;
    logic [2:0] idx;
    hit = 1'b0;
    idx = 3'h0;
    gnt_out = 6'h00;
    pick = last_q;
    for (int k = 1; k <= 6; k++) begin
      idx = 3'((int'(last_q) + k) % 6);
      if (!hit && req_in[idx]) begin
        gnt_out[idx] = 1'b1;
        pick = idx;
        hit = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      last_q <= 3'h5;
    end else if (adv_in) begin
      last_q <= pick;
    end
  end
endmodule

// File: design/sdma_core.sv
/*
  Six-channel memory transfer engine: register port, arbitration, address
  stepping, element and frame counting, reload, event pacing and interrupt
  routing. Assumes memory returns read data in the cycle after the read
  request and accepts a write in one cycle; event inputs other than the
  external interrupt pin are one-cycle pulses on mclk_in.
*/
`timescale 1ns/1ps
`include "sdma_regs.svh"

module sdma_core
  import sdma_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [15:0] reg_rdata_out,
  output sdma_mem_s mem_out,
  input wire logic [15:0] mem_rdata_in,
  input wire logic cpu_req_in,
  output logic cpu_grant_out,
  input wire sdma_evt_s sync_evt_in,
  input wire logic ext_int3_in,
  output logic [3:0] int_line_out,
  output logic [1:0] chan45_int_out
);
  sdma_state_e state_q, state_d;
  logic [2:0] act_q;
  logic hsec_q, last_q, blk_q, half_pt_q;
  logic [15:0] src_q [`SDMA_NCH];
  logic [15:0] src_d [`SDMA_NCH];
  logic [15:0] dst_q [`SDMA_NCH];
  logic [15:0] dst_d [`SDMA_NCH];
  logic [15:0] cnt_q [`SDMA_NCH];
  logic [15:0] cnt_d [`SDMA_NCH];
  logic [15:0] ini_q [`SDMA_NCH];
  logic [15:0] ini_d [`SDMA_NCH];
  logic [7:0] frm_q [`SDMA_NCH];
  logic [7:0] frm_d [`SDMA_NCH];
  logic [3:0] syn_q [`SDMA_NCH];
  logic [3:0] syn_d [`SDMA_NCH];
  sdma_mode_s mod_q [`SDMA_NCH];
  sdma_mode_s mod_d [`SDMA_NCH];
  logic [15:0] gsrc_q, gdst_q, gcnt_q;
  logic [7:0] gfrm_q;
  sdma_index_s idx_q;
  logic [5:0] en_q, prio_q, pend_q;
  logic [1:0] route_q;
  sdma_mem_s mem_q, mem_d;
  logic cpu_grant_q;
  logic [15:0] rdata_q;
  logic [3:0] line_q;
  logic [1:0] c45_q;
  logic ext3_s1_q, ext3_s2_q, ext3_s3_q;

  function automatic logic [2:0] oh_idx(input logic [5:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int k = 0; k < 6; k++) begin
      if (v[k]) begin
        r = 3'(k);
      end
    end
    return r;
  endfunction

  function automatic logic evt_of(input logic [3:0] code, input sdma_evt_s ev, input logic ext3);
    logic r;
    r = 1'b0;
    case (code)
      `SDMA_SYN_S0RX: r = ev.ser0_rx;
      `SDMA_SYN_S0TX: r = ev.ser0_tx;
      `SDMA_SYN_S1RX: r = ev.ser1_rx;
      `SDMA_SYN_S1TX: r = ev.ser1_tx;
      `SDMA_SYN_TMR0: r = ev.timer0;
      `SDMA_SYN_EXT3: r = ext3;
      `SDMA_SYN_TMR1: r = ev.timer1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // register port decode
  wire [4:0] page = reg_addr_in[7:3];
  wire [2:0] sub = reg_addr_in[2:0];
  wire [2:0] pch = page[2:0];
  wire glb_wr = reg_wr_in && (page == `SDMA_GLB_PAGE);
  wire ctl_wr = reg_wr_in && (page == `SDMA_CTL_PAGE) && (sub == `SDMA_C_PREC);
  wire ext3_rise = ext3_s2_q && !ext3_s3_q;
  logic [5:0] ch_wr, evt_hit, sync_ok;

  genvar g;
  generate
    for (g = 0; g < `SDMA_NCH; g++) begin : g_ch
      assign ch_wr[g] = reg_wr_in && (page == 5'(g));
      assign evt_hit[g] = evt_of(syn_q[g], sync_evt_in, ext3_rise);
      assign sync_ok[g] = (syn_q[g] == `SDMA_SYN_NONE) || pend_q[g];
    end
  endgenerate

  // arbitration
  wire [5:0] elig = en_q & sync_ok;
  wire [5:0] hi_req = elig & prio_q;
  wire [5:0] lo_req = elig & ~prio_q;
  wire use_hi = |hi_req;
  wire idle = (state_q == ST_IDLE);
  wire take = idle && (|elig);
  logic [5:0] gnt_hi, gnt_lo;
  wire [5:0] gnt = use_hi ? gnt_hi : gnt_lo;
  wire [2:0] gnt_idx = oh_idx(gnt);
  wire [2:0] nxt_ch = idle ? gnt_idx : act_q;

  sdma_rr_arb u_arb_hi (
    .mclk_in(mclk_in),
    .rstn_in(rstn_in),
    .req_in(hi_req),
    .adv_in(take && use_hi),
    .gnt_out(gnt_hi)
  );

  sdma_rr_arb u_arb_lo (
    .mclk_in(mclk_in),
    .rstn_in(rstn_in),
    .req_in(lo_req),
    .adv_in(take && !use_hi),
    .gnt_out(gnt_lo)
  );

  // active channel view
  sdma_mode_s cur_mode;
  assign cur_mode = mod_q[act_q];
  wire [15:0] cur_cnt = cnt_q[act_q];
  wire [7:0] cur_frm = frm_q[act_q];
  wire [15:0] cur_src = src_q[act_q];
  wire [15:0] cur_dst = dst_q[act_q];
  wire two = cur_mode.dword_mode;
  wire autor = cur_mode.auto_reload_enable;
  wire rd_fire = (state_q == ST_RD);
  wire wr_fire = (state_q == ST_WR);
  wire elem_end = rd_fire && (!two || hsec_q);
  wire wr_end = wr_fire && (!two || hsec_q);
  wire last_elem = (cur_cnt == 16'h0000);
  wire blk_now = last_elem && (cur_frm == 8'h00);
  wire last_xfer = elem_end && last_elem;
  wire [15:0] cnt_dec = cur_cnt - 16'h0001;
  wire [15:0] ini_half = ini_q[act_q] >> 1;
  wire half_hit = (cnt_dec == ini_half);
  logic [15:0] src_step, dst_step;

  sdma_addr_step u_src_step (
    .addr_in(cur_src),
    .mode_in(cur_mode.src_mode),
    .sel_in(cur_mode.source_index_select),
    .last_in(last_xfer),
    .idx_in(idx_q),
    .addr_out(src_step)
  );

  sdma_addr_step u_dst_step (
    .addr_in(cur_dst),
    .mode_in(cur_mode.dst_mode),
    .sel_in(cur_mode.destination_index_select),
    .last_in(last_q && (!two || hsec_q)),
    .idx_in(idx_q),
    .addr_out(dst_step)
  );

  // engine sequence
  always_comb begin
    case (state_q)
      ST_IDLE: state_d = take ? ST_RD : ST_IDLE;
      ST_RD: state_d = ST_LAT;
      ST_LAT: state_d = ST_WR;
      ST_WR: state_d = (two && !hsec_q) ? ST_RD : ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  wire hsec_d = (wr_fire && two && !hsec_q) ? 1'b1 : (wr_end ? 1'b0 : hsec_q);
  assign mem_d.req = (state_d == ST_RD) || (state_d == ST_WR);
  assign mem_d.we = (state_d == ST_WR);
  assign mem_d.addr = (state_d == ST_RD) ? src_q[nxt_ch] : cur_dst;
  assign mem_d.wdata = (state_d == ST_WR) ? mem_rdata_in : 16'h0000;
  wire cpu_grant_d = cpu_req_in && !mem_d.req;

  // channel context next values; a register write wins over the engine
  always_comb begin
    src_d = src_q;
    dst_d = dst_q;
    cnt_d = cnt_q;
    ini_d = ini_q;
    frm_d = frm_q;
    syn_d = syn_q;
    mod_d = mod_q;
    if (rd_fire) begin
      src_d[act_q] = (blk_now && last_xfer && autor) ? gsrc_q : src_step;
    end
    if (elem_end) begin
      if (!last_elem) begin
        cnt_d[act_q] = cnt_dec;
      end else if (!blk_now) begin
        cnt_d[act_q] = ini_q[act_q];
        frm_d[act_q] = cur_frm - 8'h01;
      end else if (autor) begin
        cnt_d[act_q] = gcnt_q;
        ini_d[act_q] = gcnt_q;
        frm_d[act_q] = gfrm_q;
      end
    end
    if (wr_fire) begin
      dst_d[act_q] = (wr_end && blk_q && autor) ? gdst_q : dst_step;
    end
    for (int i = 0; i < `SDMA_NCH; i++) begin
      if (ch_wr[i]) begin
        case (sub)
          `SDMA_CH_SRC: src_d[i] = reg_wdata_in;
          `SDMA_CH_DST: dst_d[i] = reg_wdata_in;
          `SDMA_CH_CNT: begin
            cnt_d[i] = reg_wdata_in;
            ini_d[i] = reg_wdata_in;
          end
          `SDMA_CH_SFC: begin
            syn_d[i] = reg_wdata_in[`SDMA_SYN_HI:`SDMA_SYN_LO];
            frm_d[i] = reg_wdata_in[`SDMA_FRM_HI:`SDMA_FRM_LO];
          end
          `SDMA_CH_MOD: mod_d[i] = sdma_mode_s'({reg_wdata_in[15:5], `SDMA_MOD_SPARE});
          default: ;
        endcase
      end
    end
  end

  // enables, pacing and interrupt events
  wire [5:0] act_oh = 6'h01 << act_q;
  wire [5:0] en_clr = (wr_end && blk_q && !autor) ? act_oh : 6'h00;
  wire [5:0] en_d = ctl_wr ? reg_wdata_in[`SDMA_EN_HI:`SDMA_EN_LO] : (en_q & ~en_clr);
  wire [5:0] pend_d = evt_hit | (pend_q & ~(take ? gnt : 6'h00));
  wire im = cur_mode.interrupt_mode_bit;
  wire int_cond = cur_mode.auto_buffer_mode ? (blk_q || (im && half_pt_q)) : (blk_q || (im && last_q));
  wire [5:0] chan_evt = (wr_end && cur_mode.channel_interrupt_enable && int_cond) ? act_oh : 6'h00;
  wire rt_all = (route_q == `SDMA_RT_ALL);
  wire rt_23 = rt_all || (route_q == `SDMA_RT_CH23);
  wire [3:0] line_d = {rt_23 ? chan_evt[3] : sync_evt_in.ser1_tx,
                       rt_23 ? chan_evt[2] : sync_evt_in.ser1_rx,
                       rt_all ? chan_evt[1] : sync_evt_in.timer1,
                       rt_all && chan_evt[0]};

  // register read mux
  wire [15:0] ch_word = (sub == `SDMA_CH_SRC) ? src_q[pch] :
                        (sub == `SDMA_CH_DST) ? dst_q[pch] :
                        (sub == `SDMA_CH_CNT) ? cnt_q[pch] :
                        (sub == `SDMA_CH_SFC) ? {syn_q[pch], 4'h0, frm_q[pch]} :
                        (sub == `SDMA_CH_MOD) ? 16'(mod_q[pch]) : 16'h0000;
  wire [15:0] glb_word = (sub == `SDMA_G_SRC) ? gsrc_q :
                         (sub == `SDMA_G_DST) ? gdst_q :
                         (sub == `SDMA_G_CNT) ? gcnt_q :
                         (sub == `SDMA_G_FRM) ? {8'h00, gfrm_q} :
                         (sub == `SDMA_G_EIA) ? idx_q.element_index_a :
                         (sub == `SDMA_G_EIB) ? idx_q.element_index_b :
                         (sub == `SDMA_G_FIA) ? idx_q.frame_index_a : idx_q.frame_index_b;
  wire [15:0] ctl_word = (sub == `SDMA_C_PREC) ? {route_q, prio_q, 2'b00, en_q} :
                         (sub == `SDMA_C_STAT) ? {4'h0, pend_q, state_q, 1'b0, act_q} : 16'h0000;
  wire [15:0] rd_mux = (page < 5'h06) ? ch_word :
                       (page == `SDMA_GLB_PAGE) ? glb_word :
                       (page == `SDMA_CTL_PAGE) ? ctl_word : 16'h0000;

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < `SDMA_NCH; i++) begin
        src_q[i] <= `SDMA_RST_WORD;
        dst_q[i] <= `SDMA_RST_WORD;
        cnt_q[i] <= `SDMA_RST_WORD;
        ini_q[i] <= `SDMA_RST_WORD;
        frm_q[i] <= `SDMA_RST_FRM;
        syn_q[i] <= `SDMA_RST_SYN;
        mod_q[i] <= sdma_mode_s'(`SDMA_RST_WORD);
      end
    end else begin
      src_q <= src_d;
      dst_q <= dst_d;
      cnt_q <= cnt_d;
      ini_q <= ini_d;
      frm_q <= frm_d;
      syn_q <= syn_d;
      mod_q <= mod_d;
    end
  end

  // global reloads may be rewritten at any time; they are read only at block end
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      gsrc_q <= `SDMA_RST_WORD;
      gdst_q <= `SDMA_RST_WORD;
      gcnt_q <= `SDMA_RST_WORD;
      gfrm_q <= `SDMA_RST_FRM;
      idx_q <= sdma_index_s'({4{`SDMA_RST_WORD}});
    end else if (glb_wr) begin
      case (sub)
        `SDMA_G_SRC: gsrc_q <= reg_wdata_in;
        `SDMA_G_DST: gdst_q <= reg_wdata_in;
        `SDMA_G_CNT: gcnt_q <= reg_wdata_in;
        `SDMA_G_FRM: gfrm_q <= reg_wdata_in[7:0];
        `SDMA_G_EIA: idx_q.element_index_a <= reg_wdata_in;
        `SDMA_G_EIB: idx_q.element_index_b <= reg_wdata_in;
        `SDMA_G_FIA: idx_q.frame_index_a <= reg_wdata_in;
        default: idx_q.frame_index_b <= reg_wdata_in;
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      prio_q <= `SDMA_RST_CH;
      route_q <= `SDMA_RST_RT;
    end else if (ctl_wr) begin
      prio_q <= reg_wdata_in[`SDMA_PRI_HI:`SDMA_PRI_LO];
      route_q <= reg_wdata_in[`SDMA_RT_HI:`SDMA_RT_LO];
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_q <= ST_IDLE;
      act_q <= 3'h0;
      hsec_q <= 1'b0;
      mem_q <= '0;
      cpu_grant_q <= 1'b0;
    end else begin
      state_q <= state_d;
      act_q <= nxt_ch;
      hsec_q <= hsec_d;
      mem_q <= mem_d;
      cpu_grant_q <= cpu_grant_d;
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      last_q <= 1'b0;
      blk_q <= 1'b0;
      half_pt_q <= 1'b0;
    end else if (elem_end) begin
      last_q <= last_elem;
      blk_q <= blk_now;
      half_pt_q <= half_hit;
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      en_q <= `SDMA_RST_CH;
      pend_q <= `SDMA_RST_CH;
      line_q <= 4'h0;
      c45_q <= 2'b00;
      rdata_q <= `SDMA_RST_WORD;
      ext3_s1_q <= 1'b0;
      ext3_s2_q <= 1'b0;
      ext3_s3_q <= 1'b0;
    end else begin
      en_q <= en_d;
      pend_q <= pend_d;
      line_q <= line_d;
      c45_q <= chan_evt[5:4];
      rdata_q <= reg_rd_in ? rd_mux : 16'h0000;
      ext3_s1_q <= ext_int3_in;
      ext3_s2_q <= ext3_s1_q;
      ext3_s3_q <= ext3_s2_q;
    end
  end

  assign reg_rdata_out = rdata_q;
  assign mem_out = mem_q;
  assign cpu_grant_out = cpu_grant_q;
  assign int_line_out = line_q;
  assign chan45_int_out = c45_q;

  // checks
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rstn_in);

  wire [15:0] cur_cnt_w = cnt_q[act_q];
  wire [15:0] cur_src_w = src_q[act_q];
  wire ser1_rx_w = sync_evt_in.ser1_rx;

  property p_engine_first;
    mem_q.req |-> !cpu_grant_q;
  endproperty
  a_engine_first: assert property (p_engine_first) else $error("processor granted during engine access");

  property p_hi_level;
    (take && use_hi) |-> (prio_q[gnt_idx] && en_q[gnt_idx]);
  endproperty
  a_hi_level: assert property (p_hi_level) else $error("low level served over high level");

  property p_src_const;
    (rd_fire && cur_mode.src_mode == AM_CONST && !(blk_now && last_xfer && autor) && !reg_wr_in)
      |=> (cur_src_w == $past(cur_src_w));
  endproperty
  a_src_const: assert property (p_src_const) else $error("constant source address moved");

  property p_elem_dec;
    (elem_end && !last_elem && !reg_wr_in) |=> (cur_cnt_w == $past(cur_cnt_w) - 16'h0001);
  endproperty
  a_elem_dec: assert property (p_elem_dec) else $error("element count not decremented after read");

  property p_single_frame;
    (elem_end && cur_cnt == 16'h0000 && cur_frm == 8'h00) |=> (blk_q && state_q == ST_LAT);
  endproperty
  a_single_frame: assert property (p_single_frame) else $error("zero frame count did not end block");

  property p_dword_pair;
    (wr_fire && two && !hsec_q) |=> (state_q == ST_RD) ##1 (state_q == ST_LAT) ##1 (state_q == ST_WR && hsec_q);
  endproperty
  a_dword_pair: assert property (p_dword_pair) else $error("doubleword halves not back to back");

  property p_int_gate;
    (|chan_evt) |-> (cur_mode.channel_interrupt_enable && ((chan_evt & ~act_oh) == 6'h00));
  endproperty
  a_int_gate: assert property (p_int_gate) else $error("interrupt raised while disabled");

  property p_route_none;
    (route_q == `SDMA_RT_NONE) |=> (int_line_out[2] == $past(ser1_rx_w));
  endproperty
  a_route_none: assert property (p_route_none) else $error("line 10 not left to serial receive");

  property p_auto_reload;
    (wr_end && blk_q && autor && !reg_wr_in) |=> (dst_q[$past(act_q)] == $past(gdst_q));
  endproperty
  a_auto_reload: assert property (p_auto_reload) else $error("destination not reloaded at block end");

  c_dword: cover property (wr_fire && two && hsec_q);
  c_block_auto: cover property (wr_end && blk_q && autor);
  c_chan_int: cover property (|chan_evt);
endmodule

// File: verification/sdma_mem_model.sv
/*
  Zero-wait memory beside the transfer engine, 256 words.
  Assumes read data is wanted only in the cycle after a read command.
*/
`timescale 1ns/1ps
module sdma_mem_model
  import sdma_pkg::*;
(
  input wire logic mclk_in,
  input wire sdma_mem_s mem_in,
  output logic [15:0] rdata_out
);
  logic [15:0] mem [0:255];
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 16'hA500 ^ 16'(i);
    end
    rdata_out = 16'h0000;
  end
  // raw address, no memory-mode remap
  always @(posedge mclk_in) begin
    if (mem_in.req && !mem_in.we) begin
      rdata_out <= mem[mem_in.addr[7:0]];
    end else begin
      rdata_out <= ~rdata_out;
    end
    if (mem_in.req && mem_in.we) begin
      mem[mem_in.addr[7:0]] <= mem_in.wdata;
    end
  end
endmodule

// File: verification/sdma_core_tb.sv
/*
  Self-checking bench for the transfer engine over its register port.
  Assumes the memory model answers reads one cycle after the command.
*/
`timescale 1ns/1ps
module sdma_core_tb;
  import sdma_pkg::*;
  logic mclk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [15:0] reg_wdata_in = 16'h0000;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [15:0] reg_rdata_out;
  sdma_mem_s mem_out;
  logic [15:0] mem_rdata_in;
  logic cpu_req_in = 1'b1;
  logic cpu_grant_out;
  sdma_evt_s sync_evt_in = '0;
  logic ext_int3_in = 1'b0;
  logic [3:0] int_line_out;
  logic [1:0] chan45_int_out;
  int num_errors = 0;
  int tests_run = 0;
  int n6 = 0;
  int n7 = 0;
  int n10 = 0;
  int n4 = 0;
  logic [15:0] d;
  always #50 mclk_in = ~mclk_in;
  sdma_core sdma_core_inst (.mclk_in(mclk_in), .rstn_in(rstn_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .mem_out(mem_out), .mem_rdata_in(mem_rdata_in), .cpu_req_in(cpu_req_in), .cpu_grant_out(cpu_grant_out),
    .sync_evt_in(sync_evt_in), .ext_int3_in(ext_int3_in), .int_line_out(int_line_out),
    .chan45_int_out(chan45_int_out));
  sdma_mem_model sdma_mem_model_inst (.mclk_in(mclk_in), .mem_in(mem_out), .rdata_out(mem_rdata_in));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_wdata_in <= v;
    reg_wr_in <= 1'b1;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge mclk_in);
    reg_rd_in <= 1'b0;
    #1 v = reg_rdata_out;
  endtask
  task automatic wait_idle(input logic [5:0] m);
    for (int i = 0; i < 200; i++) begin
      rd(8'h38, d);
      if ((d[5:0] & m) === 6'h00) return;
    end
    chk(d & 16'(m), 16'h0000);
  endtask
  task automatic chan(input logic [7:0] b, input logic [15:0] s, input logic [15:0] t, input logic [15:0] c,
                      input logic [15:0] f, input logic [15:0] m);
    wr(b, s);
    wr(b + 8'h01, t);
    wr(b + 8'h02, c);
    wr(b + 8'h03, f);
    wr(b + 8'h04, m);
  endtask
  task automatic pulse(input sdma_evt_s e);
    @(posedge mclk_in);
    sync_evt_in <= e;
    @(posedge mclk_in);
    sync_evt_in <= '0;
    repeat (12) @(posedge mclk_in);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge mclk_in) begin
    if (int_line_out[0] === 1'b1) n6++;
    if (int_line_out[1] === 1'b1) n7++;
    if (int_line_out[2] === 1'b1) n10++;
    if (chan45_int_out[0] === 1'b1) n4++;
    if (mem_out.req === 1'b1 && cpu_grant_out !== 1'b0) chk(16'(cpu_grant_out), 16'h0000);
  end
  initial begin
    #2000000;
    num_errors++;
    end_of_test();
  end
  initial begin
    repeat (8) @(posedge mclk_in);
    rstn_in <= 1'b1;
    rd(8'h38, d);
    chk(d, 16'h0000);
    rd(8'h03, d);
    chk(d, 16'h0000);
    chk(16'(cpu_grant_out), 16'h0001);
    $display("test reset done");
    chan(8'h00, 16'h0010, 16'h0080, 16'h0002, 16'h0000, 16'h2240);
    wr(8'h38, 16'h8001);
    wait_idle(6'h01);
    for (int i = 0; i < 3; i++) begin
      chk(sdma_mem_model_inst.mem[8'h80 + i], 16'hA510 + 16'(i));
    end
    chk(16'(n6), 16'h0001);
    $display("test linear done");
    wr(8'h34, 16'h0002);
    wr(8'h36, 16'h0010);
    chan(8'h08, 16'h0020, 16'h0090, 16'h0001, 16'h0001, 16'h6640);
    wr(8'h38, 16'h8002);
    wait_idle(6'h02);
    chk(sdma_mem_model_inst.mem[8'h90], 16'hA520);
    chk(sdma_mem_model_inst.mem[8'h91], 16'hA522);
    chk(sdma_mem_model_inst.mem[8'h92], 16'hA532);
    chk(sdma_mem_model_inst.mem[8'h93], 16'hA534);
    chk(16'(n7), 16'h0002);
    $display("test indexed done");
    chan(8'h10, 16'h0005, 16'h00A0, 16'h0000, 16'h1000, 16'h0000);
    wr(8'h38, 16'h8004);
    repeat (20) @(posedge mclk_in);
    rd(8'h38, d);
    chk(d & 16'h0004, 16'h0004);
    pulse(6'h20);
    wait_idle(6'h04);
    chk(sdma_mem_model_inst.mem[8'hA0], 16'hA505);
    chk(16'(n10), 16'h0000);
    $display("test sync done");
    chan(8'h20, 16'h0043, 16'h00B0, 16'h0001, 16'hD000, 16'hFC40);
    wr(8'h38, 16'h9010);
    pulse(6'h02);
    wr(8'h30, 16'h0060);
    wr(8'h31, 16'h00C0);
    wr(8'h32, 16'h0003);
    wr(8'h33, 16'h0002);
    pulse(6'h02);
    for (int i = 0; i < 4; i++) begin
      chk(sdma_mem_model_inst.mem[8'hB0 + i], 16'hA543 - 16'(i));
    end
    rd(8'h20, d);
    chk(d, 16'h0060);
    rd(8'h21, d);
    chk(d, 16'h00C0);
    rd(8'h22, d);
    chk(d, 16'h0003);
    rd(8'h23, d);
    chk(d, 16'hD002);
    chk(16'(n4), 16'h0002);
    $display("test reload done");
    end_of_test();
  end
endmodule
